/* core/adr_host.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Host alone makes SCL, START and STOP; the converter is only a slave.
// - Data changes only while SCL low; high-phase changes mean START or STOP.
// - START is SDA falling while SCL high, before every command.
// - STOP is SDA rising while SCL high, ending every operation.
// - A transfer begins only while both SDA and SCL read high.
// - One SCL pulse per bit; SDA stable over the whole high phase.
// - Host chooses how many bytes pass; no upper limit. This host reads cmd_count results of two bytes each (one if cmd_count is 0), at most 2^CNT_W-1.
// - Receiver answers every byte with ACK or NAK in an extra ninth clock pulse.
// - Acknowledger holds SDA low throughout the acknowledge high phase.
// - Host withholds acknowledge after the last wanted byte; slave releases SDA.
// - Host issues STOP after the last conversion it wants.
// - Host acknowledging a result asks for another; each costs 18 SCL clocks.
module adr_host
    import adr_pkg::*;
#(
    parameter int         TICK_CYCLES = TICK_CYC,
    parameter int         CNT_W       = 8,
    parameter logic [3:0] DEV_CODE    = DEV_CODE_DEF
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             cmd_valid,
    input  wire logic             cmd_read,
    input  wire logic [2:0]       cmd_addr_sel,
    input  wire logic [CNT_W-1:0] cmd_count,
    output logic                  cmd_ready,
    output logic                  res_valid,
    output logic      [RES_W-1:0] res_data,
    output logic                  res_last,
    output logic                  done,
    output logic                  nack_err,
    output logic                  busy,
    output logic                  scl_o,
    output logic                  scl_oe,
    input  wire logic             scl_i,
    output logic                  sda_o,
    output logic                  sda_oe,
    input  wire logic             sda_i
);

    initial begin
        if (TICK_CYCLES < 2 || CNT_W < 1 || BUS_FREE_TICKS > 4) begin
            $error("adr_host parameters out of range.");
        end
    end

    // ----------------------------------------------------------------
    // Tick source and pin synchronisers
    // ----------------------------------------------------------------
    adr_tick_if tk ();

    adr_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .tk    (tk.gen)
    );

    logic [1:0] pin_raw;
    logic [1:0] pin_s;
    logic       scl_s;
    logic       sda_s;

    assign pin_raw = {scl_i, sda_i};

    adr_sync #(
        .W (2)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (pin_raw),
        .q     (pin_s)
    );

    assign scl_s = pin_s[1];
    assign sda_s = pin_s[0];

    // ----------------------------------------------------------------
    // State and datapath registers
    // ----------------------------------------------------------------
    adr_state_t       state_reg;
    adr_state_t       state_next;
    logic [1:0]       ph_reg;
    logic [2:0]       bit_reg;
    logic [1:0]       free_reg;
    logic [7:0]       sh_reg;
    logic [7:0]       rx_reg;
    logic [7:0]       hi_reg;
    logic             byte_reg;
    logic             rw_reg;
    logic [CNT_W-1:0] left_reg;
    logic             scl_oe_reg;
    logic             sda_oe_reg;
    logic             pin_lo_reg;
    logic             cmd_ready_reg;
    logic             res_valid_reg;
    logic [RES_W-1:0] res_data_reg;
    logic             res_last_reg;
    logic             done_reg;
    logic             nack_err_reg;
    logic             busy_reg;

    logic bus_idle;
    logic accept;
    logic step;
    logic bit_end;
    logic more;
    logic ack_drive;

    assign tk.run = (state_reg != S_IDLE);

    assign bus_idle = scl_s & sda_s;
    assign accept   = cmd_valid & cmd_ready_reg & bus_idle;

    // The high phase is held while a slave stretches SCL; START pulls SCL low itself.
    assign step    = tk.tick & ~((ph_reg == PH_HIGH1) & ~scl_s & (state_reg != S_START));
    assign bit_end = step & (ph_reg == PH_HIGH1);
    assign more    = (left_reg > CNT_W'(1));

    assign ack_drive = ~byte_reg | more;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (accept) begin
                    state_next = S_START;
                end
            end
            S_START: begin
                if (bit_end) begin
                    state_next = S_ADDR;
                end
            end
            S_ADDR: begin
                if (bit_end && bit_reg == LAST_BIT) begin
                    state_next = S_AACK;
                end
            end
            S_AACK: begin
                if (bit_end) begin
                    state_next = (!sda_s && rw_reg) ? S_RDB : S_STOP;
                end
            end
            S_RDB: begin
                if (bit_end && bit_reg == LAST_BIT) begin
                    state_next = S_MACK;
                end
            end
            S_MACK: begin
                if (bit_end) begin
                    state_next = ack_drive ? S_RDB : S_STOP;
                end
            end
            S_STOP: begin
                if (bit_end) begin
                    state_next = S_FREE;
                end
            end
            S_FREE: begin
                if (step && free_reg == FREE_LAST) begin
                    state_next = S_IDLE;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_reg   <= PH_LOW0;
            bit_reg  <= 3'h0;
            free_reg <= 2'h0;
        end else begin
            if (state_reg == S_IDLE) begin
                ph_reg <= PH_LOW0;
            end else if (step) begin
                ph_reg <= ph_reg + 2'h1;
            end
            if (state_next != state_reg) begin
                bit_reg <= 3'h0;
            end else if (bit_end) begin
                bit_reg <= bit_reg + 3'h1;
            end
            if (state_reg != S_FREE) begin
                free_reg <= 2'h0;
            end else if (step) begin
                free_reg <= free_reg + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    // host drives SCL
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_oe_reg <= 1'b0;
        end else if (state_reg == S_IDLE || state_reg == S_FREE) begin
            scl_oe_reg <= 1'b0;
        end else if (step) begin
            if (ph_reg == PH_LOW0 && state_reg != S_START) begin
                scl_oe_reg <= 1'b1;
            end else if (ph_reg == PH_HIGH0) begin
                scl_oe_reg <= (state_reg == S_START);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe_reg <= 1'b0;
        end else if (state_reg == S_IDLE || state_reg == S_FREE) begin
            sda_oe_reg <= 1'b0;
        end else if (step) begin
            unique case (state_reg)
                S_START: begin
                    if (ph_reg == PH_LOW0) begin
                        sda_oe_reg <= 1'b1;
                    end
                end
                S_ADDR: begin
                    if (ph_reg == PH_LOW1) begin
                        sda_oe_reg <= ~sh_reg[7];
                    end
                end
                S_AACK, S_RDB: begin
                    if (ph_reg == PH_LOW1) begin
                        sda_oe_reg <= 1'b0;
                    end
                end
                S_MACK: begin
                    // ack held low; NAK on last
                    if (ph_reg == PH_LOW1) begin
                        sda_oe_reg <= ack_drive;
                    end
                end
                S_STOP: begin
                    if (ph_reg == PH_LOW1) begin
                        sda_oe_reg <= 1'b1;
                    end else if (ph_reg == PH_HIGH1) begin
                        sda_oe_reg <= 1'b0;
                    end
                end
                default: begin
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_lo_reg <= 1'b0;
        end else begin
            pin_lo_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Command capture and byte shifting
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_reg   <= 8'h00;
            rw_reg   <= 1'b0;
            left_reg <= '0;
            byte_reg <= 1'b0;
        end else if (accept) begin
            sh_reg   <= {DEV_CODE, cmd_addr_sel, cmd_read};
            rw_reg   <= cmd_read;
            left_reg <= (cmd_count == '0) ? CNT_W'(1) : cmd_count;
            byte_reg <= 1'b0;
        end else if (bit_end) begin
            if (state_reg == S_ADDR) begin
                sh_reg <= {sh_reg[6:0], 1'b0};
            end
            if (state_reg == S_MACK) begin
                byte_reg <= ~byte_reg;
                if (byte_reg) begin
                    left_reg <= left_reg - CNT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_reg        <= 8'h00;
            hi_reg        <= 8'h00;
            res_valid_reg <= 1'b0;
            res_data_reg  <= '0;
            res_last_reg  <= 1'b0;
        end else begin
            res_valid_reg <= 1'b0;
            if (bit_end && state_reg == S_RDB) begin
                rx_reg <= {rx_reg[6:0], sda_s};
                if (bit_reg == LAST_BIT && !byte_reg) begin
                    hi_reg <= {rx_reg[6:0], sda_s};
                end
                if (bit_reg == LAST_BIT && byte_reg) begin
                    res_valid_reg <= 1'b1;
                    res_data_reg  <= {hi_reg[HI_BITS-1:0], rx_reg[LO_BITS:1]};
                    res_last_reg  <= ~more;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Status outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ready_reg <= 1'b0;
            busy_reg      <= 1'b0;
            done_reg      <= 1'b0;
            nack_err_reg  <= 1'b0;
        end else begin
            cmd_ready_reg <= (state_next == S_IDLE) & ~accept;
            busy_reg      <= (state_next != S_IDLE);
            done_reg      <= bit_end & (state_reg == S_STOP);
            if (accept) begin
                nack_err_reg <= 1'b0;
            end else if (bit_end && state_reg == S_AACK && sda_s) begin
                nack_err_reg <= 1'b1;
            end
        end
    end

    assign cmd_ready = cmd_ready_reg;
    assign res_valid = res_valid_reg;
    assign res_data  = res_data_reg;
    assign res_last  = res_last_reg;
    assign done      = done_reg;
    assign nack_err  = nack_err_reg;
    assign busy      = busy_reg;
    assign scl_o     = pin_lo_reg;
    assign scl_oe    = scl_oe_reg;
    assign sda_o     = pin_lo_reg;
    assign sda_oe    = sda_oe_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_scl_tick_only: assert property ($rose(scl_oe_reg) |-> $past(tk.tick))
        else $error("SCL pulled low without a tick.");

    a_data_scl_low: assert property (
        (state_reg inside {S_ADDR, S_AACK, S_RDB, S_MACK}) && !$stable(sda_oe_reg)
        |-> scl_oe_reg)
        else $error("SDA moved while SCL high.");

    a_start_cond: assert property (
        (state_reg == S_START) && $rose(sda_oe_reg) |-> !scl_oe_reg)
        else $error("START not formed with SCL high.");

    a_stop_cond: assert property (
        $past(state_reg == S_STOP) && $fell(sda_oe_reg) |-> !scl_oe_reg)
        else $error("STOP not formed with SCL high.");

    a_start_idle: assert property (
        (state_reg == S_IDLE) && (state_next == S_START) |-> scl_s && sda_s)
        else $error("Transfer started on a busy bus.");

    a_bit_hold: assert property (
        (state_reg inside {S_ADDR, S_MACK}) && !scl_oe_reg && $past(!scl_oe_reg)
        |-> $stable(sda_oe_reg))
        else $error("SDA changed during SCL high.");

    a_ack_release: assert property (
        (state_reg inside {S_AACK, S_RDB}) && ph_reg[1] |-> !sda_oe_reg)
        else $error("Host drove SDA in a slave slot.");

    a_nak_last: assert property (
        (state_reg == S_MACK) && byte_reg && !more && ph_reg[1] |-> !sda_oe_reg)
        else $error("Last byte was acknowledged.");

    a_result_word: assert property (
        res_valid_reg |-> $past(state_reg == S_RDB)
        && res_data_reg[RES_W-1:LO_BITS] == hi_reg[HI_BITS-1:0])
        else $error("Result word packed wrongly.");

    a_stop_done: assert property (
        done_reg |-> $past(state_reg == S_STOP) && state_reg == S_FREE)
        else $error("Done without a STOP.");

endmodule

/* core/adr_pkg.sv */
package adr_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_NS        = 650;
    localparam int TICK_CYC       = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUS_FREE_NS    = 1300;
    localparam int BUS_FREE_TICKS = (BUS_FREE_NS + TICK_NS - 1) / TICK_NS;
    localparam logic [1:0] FREE_LAST = 2'(BUS_FREE_TICKS - 1);

    // ----------------------------------------------------------------
    // Bit phases within one SCL period
    // ----------------------------------------------------------------
    localparam logic [1:0] PH_LOW0  = 2'h0;
    localparam logic [1:0] PH_LOW1  = 2'h1;
    localparam logic [1:0] PH_HIGH0 = 2'h2;
    localparam logic [1:0] PH_HIGH1 = 2'h3;

    // ----------------------------------------------------------------
    // Address byte and result layout
    // ----------------------------------------------------------------
    // Device code value is arbitrary.
    localparam logic [3:0] DEV_CODE_DEF = 4'hA;
    localparam logic [2:0] ADDR_SEL_DEF = 3'h5;
    localparam logic       RW_READ      = 1'b1;
    localparam logic [2:0] LAST_BIT     = 3'h7;
    localparam int         RES_W        = 10;
    localparam int         HI_BITS      = 4;
    localparam int         LO_BITS      = 6;

    typedef enum logic [7:0] {
        S_IDLE  = 8'h01,
        S_START = 8'h02,
        S_ADDR  = 8'h04,
        S_AACK  = 8'h08,
        S_RDB   = 8'h10,
        S_MACK  = 8'h20,
        S_STOP  = 8'h40,
        S_FREE  = 8'h80
    } adr_state_t;

endpackage

/* core/adr_sync.sv */
`timescale 1ns/1ps
module adr_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // ----------------------------------------------------------------
    // Two-stage synchroniser; idle bus level is high.
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '1;
            q_reg    <= '1;
        end else begin
            meta_reg <= d;
            q_reg    <= meta_reg;
        end
    end

    assign q = q_reg;

endmodule

/* core/adr_tick_gen.sv */
`timescale 1ns/1ps
module adr_tick_gen
    import adr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input  wire logic    clk,
    input  wire logic    rst_n,
    adr_tick_if.gen      tk
);
    localparam int CW = $clog2(TICK_CYCLES);

    initial begin
        if (TICK_CYCLES < 2) begin
            $error("TICK_CYCLES must be at least 2.");
        end
    end

    logic [CW-1:0] cnt_reg;
    logic          tick_reg;

    // ----------------------------------------------------------------
    // Quarter-period divider, restarted while idle.
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else if (!tk.run) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else if (cnt_reg == CW'(TICK_CYCLES - 1)) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b1;
        end else begin
            cnt_reg  <= cnt_reg + CW'(1);
            tick_reg <= 1'b0;
        end
    end

    assign tk.tick = tick_reg;

endmodule

/* core/adr_tick_if.sv */
`timescale 1ns/1ps
interface adr_tick_if;
    logic tick;
    logic run;
    modport gen  (input run, output tick);
    modport user (output run, input tick);
endinterface

/* testbench/adr_dev_model.sv */
`timescale 1ns/1ps
module adr_dev_model
    import adr_pkg::*;
#(
    parameter logic [3:0] DEV_CODE = DEV_CODE_DEF,
    parameter logic [2:0] SEL      = ADDR_SEL_DEF
) (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [9:0] analog_input,
    output logic            sda_oe,
    output logic            conv_evt,
    output int              start_cnt,
    output int              stop_cnt,
    output int              pulse_cnt
);
    logic [9:0]  result_reg;
    logic [7:0]  sh;
    logic [15:0] tx;
    logic        mack;
    int          st;
    int          cnt;

    // ------------------------------------------------------------
    // Converter and bus slave
    // ------------------------------------------------------------
    initial begin
        sda_oe = 1'b0;
        conv_evt = 1'b0;
        start_cnt = 0;
        stop_cnt = 0;
        pulse_cnt = 0;
        st = 0;
        cnt = 0;
    end

    task automatic convert;
        result_reg = analog_input;
        conv_evt = !conv_evt;
    endtask

    always @(negedge sda) if (scl === 1'b1) begin
        start_cnt++;
        pulse_cnt = 0;
        st = 1;
        cnt = 0;
        sda_oe = 1'b0;
    end

    always @(posedge sda) if (scl === 1'b1) begin
        stop_cnt++;
        st = 0;
        sda_oe = 1'b0;
    end

    // Bits are taken on the rising clock edge.
    always @(posedge scl) begin
        pulse_cnt++;
        if (st == 1) begin
            sh = {sh[6:0], sda};
            cnt++;
        end
        if (st == 4) mack = sda;
    end

    always @(negedge scl) begin
        case (st)
            1: if (cnt == 8) begin
                st = (sh[7:1] == {DEV_CODE, SEL}) ? 2 : 0;
                sda_oe = (st == 2);
                // Sampling starts at the read bit's falling edge.
                if (st == 2 && sh[0]) convert();
            end
            2: begin
                // A read loads both bytes, a poll releases.
                tx = {4'h0, result_reg, 2'h1};
                st = sh[0] ? 3 : 0;
                cnt = 0;
                sda_oe = sh[0] && !tx[15];
            end
            3: begin
                cnt++;
                // Next sampling at the lower byte's last falling edge.
                if (cnt == 16) convert();
                st = (cnt % 8 == 0) ? 4 : 3;
                sda_oe = (st == 3) && !tx[15 - cnt];
            end
            4: begin
                // Continue after an acknowledge, else release.
                if (cnt == 16) begin
                    tx = {4'h0, result_reg, 2'h1};
                    cnt = 0;
                end
                st = (mack === 1'b0) ? 3 : 0;
                sda_oe = (st == 3) && !tx[15 - cnt];
            end
            default: sda_oe = 1'b0;
        endcase
    end
endmodule

/* testbench/tb_adr_i2c_slave_readout.sv */
`timescale 1ns/1ps
module tb_adr_i2c_slave_readout
    import adr_pkg::*;
;
    logic             clk, rst_n, cmd_valid, cmd_read;
    logic [2:0]       cmd_addr_sel;
    logic [7:0]       cmd_count;
    logic [9:0]       analog_input;
    logic             cmd_ready, res_valid, res_last, done, nack_err, busy;
    logic [RES_W-1:0] res_data;
    logic             scl_o, scl_oe, sda_o, sda_oe, dev_oe, conv_evt;
    wire              scl, sda;
    int               start_cnt, stop_cnt, pulse_cnt, error_cnt, checks_done;
    logic [9:0]       smp_q[$];
    logic             last_q[$];

    assign scl = !(scl_oe && !scl_o);
    assign sda = !((sda_oe && !sda_o) || dev_oe);

    adr_host #(.TICK_CYCLES(4)) u_adr_host (.clk, .rst_n, .cmd_valid, .cmd_read,
        .cmd_addr_sel, .cmd_count, .cmd_ready, .res_valid, .res_data, .res_last,
        .done, .nack_err, .busy, .scl_o, .scl_oe, .scl_i(scl), .sda_o, .sda_oe,
        .sda_i(sda));

    adr_dev_model u_adr_dev_model (.scl(scl), .sda(sda), .analog_input,
        .sda_oe(dev_oe), .conv_evt, .start_cnt, .stop_cnt, .pulse_cnt);

    // ------------------------------------------------------------
    // Clock, checks and result watcher
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (!ok) begin
            error_cnt++;
            $display("ERROR t=%0t %s", $time, msg);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(conv_evt) begin
        smp_q.push_back(analog_input);
        @(posedge clk);
        analog_input <= 10'($urandom);
    end

    always @(posedge clk) if (res_valid === 1'b1) begin
        if (smp_q.size() == 0 || last_q.size() == 0) check(1'b0, "unexpected result");
        else begin
            check(res_data === smp_q.pop_front(), "result data");
            check(res_last === last_q.pop_front(), "last flag");
        end
    end

    // ------------------------------------------------------------
    // Command driver
    // ------------------------------------------------------------
    task automatic run_cmd(input logic rd, input logic [2:0] sel, input logic [7:0] n,
                           input logic ack);
        int k;
        int s0;
        int p0;
        int nres;
        nres = (n == 0) ? 1 : n;
        s0 = start_cnt;
        p0 = stop_cnt;
        if (rd && ack) for (k = 1; k <= nres; k++) last_q.push_back(k == nres);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_addr_sel <= sel;
        cmd_count <= n;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (cmd_ready !== 1'b1 && k < 5000);
        if (k >= 5000) begin
            error_cnt++;
            $display("ERROR t=%0t command not taken", $time);
            report_and_stop();
        end
        cmd_valid <= 1'b0;
        for (k = 0; k < 5000 && done !== 1'b1; k++) @(posedge clk);
        if (k >= 5000) begin
            error_cnt++;
            $display("ERROR t=%0t command timed out", $time);
            report_and_stop();
        end
        check(nack_err === !ack, "address acknowledge");
        check(start_cnt - s0 == 1 && stop_cnt - p0 == 1, "framing");
        check(pulse_cnt == 10 + ((rd && ack) ? 18 * nres : 0), "clock count");
        check(smp_q.size() == ((rd && ack) ? 1 : 0), "sampling count");
        check(last_q.size() == 0, "results missing");
        check(sda === 1'b1 && scl === 1'b1, "bus released");
        check(busy === 1'b1, "busy through bus free");
        smp_q.delete();
        last_q.delete();
        $display("test rd=%0b sel=%0d n=%0d finished", rd, sel, n);
    endtask

    initial begin
        int s;
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_read = 1'b0;
        cmd_addr_sel = 3'h0;
        cmd_count = 8'h00;
        analog_input = 10'h3A5;
        error_cnt = 0;
        checks_done = 0;
        s = $urandom(32'h4d2d);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        smp_q.delete();
        run_cmd(1'b1, ADDR_SEL_DEF, 8'h01, 1'b1);
        run_cmd(1'b1, ADDR_SEL_DEF, 8'h03, 1'b1);
        run_cmd(1'b1, ADDR_SEL_DEF, 8'h00, 1'b1);
        run_cmd(1'b0, ADDR_SEL_DEF, 8'h02, 1'b1);
        for (s = 0; s < 8; s++) begin
            run_cmd(1'(s % 2), 3'(s), 8'($urandom_range(4, 1)), 3'(s) == ADDR_SEL_DEF);
        end
        report_and_stop();
    end
endmodule
